// ==== eec_pkg.sv ====
// constants and types for the two-wire serial eeprom master
// Contract
// - SDA falls while SCL high: START
// - SDA rises while SCL high: STOP
// - SDA changes only while SCL low
// - master starts only on an idle bus
// - receiver pulls SDA low on ninth clock
// - master makes clock, START, STOP, ack clock
// - master keeps page writes inside one page
// - poll with write control byte until acked; master sends it once per command and reports a nack in status
// - master ends read with nack then STOP
// - random read: address, repeated START, read
// - master ack on read continues with next byte
package eec_pkg;

  typedef enum logic [1:0] {
    EEC_OP_WRITE,
    EEC_OP_READ_CUR,
    EEC_OP_READ_RAND,
    EEC_OP_POLL
  } eec_op_e;

  // cnt_m1 is the byte count minus one, so one to eight bytes
  typedef struct packed {
    eec_op_e    op;
    logic [7:0] addr;
    logic [2:0] cnt_m1;
  } eec_cmd_s;

  typedef struct packed {
    logic nack;
    logic bad_page;
  } eec_sts_s;

  localparam int CLK_PERIOD_NS  = 4;
  localparam int SCL_PERIOD_NS  = 3000;
  localparam int T_HIGH_MIN_NS  = 600;
  localparam int QUARTER_CYC    =
    (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIGH_MIN_CYC   =
    (T_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W          = 10;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(QUARTER_CYC - 1);

  localparam logic [3:0] CTL_CODE  = 4'ha;
  localparam logic [2:0] CTL_CHIP  = 3'h0;
  localparam logic       RW_READ   = 1'b1;
  localparam logic       RW_WRITE  = 1'b0;
  localparam logic [3:0] ACK_BIT   = 4'h8;
  localparam logic [1:0] Q_LAST    = 2'h3;
  localparam logic [3:0] PAGE_LAST = 4'h7;

  function automatic logic [7:0] ctl_byte(input logic rw);
    ctl_byte = {CTL_CODE, CTL_CHIP, rw};
  endfunction : ctl_byte

  function automatic logic crosses_page(input eec_cmd_s c);
    crosses_page = ({1'b0, c.addr[2:0]} + {1'b0, c.cnt_m1}) > PAGE_LAST;
  endfunction : crosses_page

endpackage : eec_pkg

// ==== eec_master.sv ====
// two-wire bus master driving a small serial eeprom
`timescale 1ns/100ps
`default_nettype none
module eec_master (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  wire eec_pkg::eec_cmd_s cmd,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [7:0]       wr_data,
  output logic                  rd_valid,
  output logic [7:0]            rd_data,
  output logic                  done,
  output eec_pkg::eec_sts_s     status,
  output logic                  scl,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_n
);

  typedef enum {
    S_IDLE, S_START, S_CTL, S_ADDR, S_WAIT, S_WDATA,
    S_RSTART, S_CTLR, S_RDATA, S_STOP, S_DONE
  } eec_state_e;

  eec_state_e                  state;
  eec_pkg::eec_cmd_s           cmd_q;
  eec_pkg::eec_sts_s           sts;
  logic [eec_pkg::DIV_W-1:0]   div;
  logic                        tick;
  logic [1:0]                  qcnt;
  logic [3:0]                  bcnt;
  logic [2:0]                  remain;
  logic [7:0]                  shreg;
  logic                        sda_meta;
  logic                        sda_sync;
  logic                        tx_state;
  logic                        slot_end;
  logic                        byte_end;
  logic [11:0]                 hi_cnt;

  assign sda_o     = 1'b0;
  assign tick      = (div == eec_pkg::DIV_LAST);
  assign tx_state  = (state == S_CTL) || (state == S_ADDR) ||
                     (state == S_WDATA) || (state == S_CTLR);
  assign slot_end  = tick && (qcnt == eec_pkg::Q_LAST);
  assign byte_end  = slot_end && (bcnt == eec_pkg::ACK_BIT);
  assign wr_ready  = (state == S_WAIT);
  assign cmd_ready = (state == S_IDLE) && sda_sync && scl;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      sda_meta <= sda_i;
      sda_sync <= sda_meta;
    end
  end

  // quarter-bit divider; bus clock derived from clk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= '0;
    end else if (state == S_IDLE || state == S_WAIT || tick) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qcnt <= '0;
      bcnt <= '0;
    end else if (state == S_IDLE || state == S_WAIT) begin
      qcnt <= '0;
      bcnt <= '0;
    end else if (tick) begin
      qcnt <= qcnt + 1'b1;
      if (qcnt == eec_pkg::Q_LAST) begin
        bcnt <= (bcnt == eec_pkg::ACK_BIT || state == S_START ||
                 state == S_RSTART) ? 4'h0 : bcnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl      <= 1'b1;
      sda_oe_n <= 1'b1;
    end else if (tick) begin
      case (qcnt)
        2'h0: begin
          if (state == S_START || state == S_RSTART) begin
            sda_oe_n <= 1'b1;
          end else if (state == S_STOP) begin
            sda_oe_n <= 1'b0;
          end else if (tx_state) begin
            sda_oe_n <= (bcnt == eec_pkg::ACK_BIT) ? 1'b1 : shreg[7];
          end else if (state == S_RDATA) begin
            // ack to continue, nack on last
            sda_oe_n <= (bcnt == eec_pkg::ACK_BIT) ? (remain == 3'h0)
                                                   : 1'b1;
          end
        end
        2'h1: scl <= 1'b1;
        2'h2: begin
          if (state == S_START || state == S_RSTART) begin
            sda_oe_n <= 1'b0;
          end else if (state == S_STOP) begin
            sda_oe_n <= 1'b1;
          end
        end
        default: begin
          if (state != S_STOP) begin
            scl <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= S_IDLE;
      cmd_q    <= '0;
      sts      <= '0;
      remain   <= '0;
      shreg    <= '0;
      rd_valid <= 1'b0;
      rd_data  <= '0;
      done     <= 1'b0;
      status   <= '0;
    end else begin
      rd_valid <= 1'b0;
      done     <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_q  <= cmd;
            remain <= cmd.cnt_m1;
            sts    <= '0;
            // refuse a write that crosses a page
            if (cmd.op == eec_pkg::EEC_OP_WRITE &&
                eec_pkg::crosses_page(cmd)) begin
              sts.bad_page <= 1'b1;
              state        <= S_DONE;
            end else begin
              state <= S_START;
            end
          end
        end
        S_START, S_RSTART: begin
          if (slot_end) begin
            // control byte with code and direction
            if (state == S_RSTART ||
                cmd_q.op == eec_pkg::EEC_OP_READ_CUR) begin
              shreg <= eec_pkg::ctl_byte(eec_pkg::RW_READ);
              state <= S_CTLR;
            end else begin
              shreg <= eec_pkg::ctl_byte(eec_pkg::RW_WRITE);
              state <= S_CTL;
            end
          end
        end
        S_WAIT: begin
          if (wr_valid) begin
            shreg <= wr_data;
            state <= S_WDATA;
          end
        end
        S_CTL, S_ADDR, S_WDATA, S_CTLR, S_RDATA: begin
          if (tick && qcnt == 2'h2 && bcnt != eec_pkg::ACK_BIT) begin
            shreg <= tx_state ? {shreg[6:0], 1'b0}
                              : {shreg[6:0], sda_sync};
          end
          // slave ack sampled on ninth clock
          if (tick && qcnt == 2'h2 && bcnt == eec_pkg::ACK_BIT &&
              tx_state && sda_sync) begin
            sts.nack <= 1'b1;
          end
          if (byte_end) begin
            if (tx_state && sts.nack) begin
              state <= S_STOP;
            end else begin
              case (state)
                S_CTL: begin
                  // poll ends after the control byte
                  if (cmd_q.op == eec_pkg::EEC_OP_POLL) begin
                    state <= S_STOP;
                  end else begin
                    shreg <= cmd_q.addr;
                    state <= S_ADDR;
                  end
                end
                S_ADDR: begin
                  state <= (cmd_q.op == eec_pkg::EEC_OP_READ_RAND)
                           ? S_RSTART : S_WAIT;
                end
                S_WDATA: begin
                  // up to eight bytes, then STOP
                  remain <= remain - 1'b1;
                  state  <= (remain == 3'h0) ? S_STOP : S_WAIT;
                end
                S_CTLR: state <= S_RDATA;
                default: begin
                  rd_valid <= 1'b1;
                  rd_data  <= shreg;
                  remain   <= remain - 1'b1;
                  state    <= (remain == 3'h0) ? S_STOP : S_RDATA;
                end
              endcase
            end
          end
        end
        S_STOP: begin
          if (slot_end) begin
            state <= S_DONE;
          end
        end
        S_DONE: begin
          done   <= 1'b1;
          status <= sts;
          state  <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt <= '0;
    end else if (!scl) begin
      hi_cnt <= '0;
    end else if (hi_cnt != 12'hfff) begin
      hi_cnt <= hi_cnt + 1'b1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  start_cond_a: assert property (
    ($fell(sda_oe_n) && scl) |-> (state == S_START || state == S_RSTART))
    else $error("sda pulled low with scl high outside start");
  stop_cond_a: assert property (
    ($rose(sda_oe_n) && scl) |-> (state == S_STOP))
    else $error("sda released with scl high outside stop");
  data_stable_a: assert property (
    (scl && $past(scl) && tx_state) |-> $stable(sda_oe_n))
    else $error("sda changed during scl high");
  idle_start_a: assert property (
    (state == S_IDLE ##1 state == S_START) |-> $past(sda_sync) && scl)
    else $error("start issued on a busy bus");
  ack_release_a: assert property (
    (tx_state && bcnt == eec_pkg::ACK_BIT && scl) |-> sda_oe_n)
    else $error("master drove sda in slave ack slot");
  scl_high_a: assert property (
    $fell(scl) |-> ($past(hi_cnt) >= eec_pkg::HIGH_MIN_CYC))
    else $error("scl high phase too short");
  page_guard_a: assert property (
    (cmd_valid && cmd_ready && cmd.op == eec_pkg::EEC_OP_WRITE &&
     eec_pkg::crosses_page(cmd)) |=> (state == S_DONE) ##1 done)
    else $error("page crossing write not refused");
  poll_stop_a: assert property (
    (state == S_CTL && byte_end && cmd_q.op == eec_pkg::EEC_OP_POLL)
    |=> (state == S_STOP))
    else $error("poll did not end with stop");
  read_nack_a: assert property (
    (state == S_RDATA && bcnt == eec_pkg::ACK_BIT && remain == 3'h0 &&
     scl) |-> sda_oe_n)
    else $error("last read byte was acked");
  read_ack_a: assert property (
    (state == S_RDATA && bcnt == eec_pkg::ACK_BIT && remain != 3'h0 &&
     scl) |-> !sda_oe_n)
    else $error("continuing read byte not acked");
  rand_restart_a: assert property (
    (state == S_ADDR && byte_end && !sts.nack &&
     cmd_q.op == eec_pkg::EEC_OP_READ_RAND) |=> (state == S_RSTART))
    else $error("random read missed repeated start");

endmodule : eec_master
`default_nettype wire

// ==== eec_eeprom_model.sv ====
// behavioural two-wire eeprom slave facing the master
`timescale 1ns/100ps
`default_nettype none
module eec_eeprom_model #(
  parameter int BUSY_NS = 1000
) (
  input  wire logic scl,
  input  wire logic sda,
  output var  logic sda_low
);
  logic [7:0] mem [256];
  logic [7:0] pbuf [8];
  logic [7:0] valid;
  logic [7:0] ptr;
  logic [7:0] sh;
  logic [3:0] bcnt;
  logic [2:0] st;
  logic       busy;
  logic       mack;
  logic       ok;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
    sda_low = 1'b0;
    busy = 1'b0;
    st = 3'h0;
    ptr = 8'h00;
    valid = 8'h00;
  end

  // start, repeated start drops pending write
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      st = 3'h1;
      bcnt = 4'hf;
      valid = 8'h00;
    end
  end

  always @(posedge sda) begin
    if (scl === 1'b1) begin
      st = 3'h0;
      if (valid != 8'h00) begin
        for (int i = 0; i < 8; i++)
          if (valid[i]) mem[{ptr[7:3], 3'(i)}] = pbuf[i];
        valid = 8'h00;
        busy = 1'b1;
        busy <= #(BUSY_NS) 1'b0;
      end
    end
  end

  always @(posedge scl) begin
    if (bcnt < 4'h8) sh = {sh[6:0], sda};
    else mack = ~sda;
  end

  task automatic step();
    case (st)
      // read or write by last bit
      3'h1: st = !ok ? 3'h0 : (sh[0] ? 3'h4 : 3'h2);
      3'h2: begin
        ptr = sh;
        st = 3'h3;
      end
      3'h3: begin
        pbuf[ptr[2:0]] = sh;
        valid[ptr[2:0]] = 1'b1;
        ptr[2:0] = ptr[2:0] + 3'h1;
      end
      default: begin
        ptr = ptr + 8'h01;
        if (!mack) st = 3'h0;
      end
    endcase
  endtask : step

  always @(negedge scl) begin
    if (st != 3'h0) begin
      bcnt = bcnt + 4'h1;
      if (bcnt == 4'h9) begin
        bcnt = 4'h0;
        sda_low = 1'b0;
        step();
      end else if (bcnt == 4'h8) begin
        ok = (st != 3'h1) || (sh[7:4] == 4'ha && !busy);
        sda_low = (st != 3'h4) && ok;
      end
      if (st == 3'h4 && bcnt < 4'h8) sda_low = ~mem[ptr][7 - bcnt];
    end
  end
endmodule : eec_eeprom_model
`default_nettype wire

// ==== eec_tb.sv ====
// bench for the two-wire eeprom master against a behavioural eeprom
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic              clk;
  logic              rst_n;
  logic              cmd_valid;
  logic              cmd_ready;
  eec_pkg::eec_cmd_s cmd;
  logic              wr_valid;
  logic              wr_ready;
  logic [7:0]        wr_data;
  logic              rd_valid;
  logic [7:0]        rd_data;
  logic              done;
  eec_pkg::eec_sts_s status;
  logic              scl;
  logic              sda_o;
  logic              sda_oe_n;
  logic              sda_low;
  logic              sda;
  int                n_errors;
  int                checked;
  logic [7:0]        rd_q[$];

  // open drain with pull-up
  assign sda = sda_oe_n ? !sda_low : (sda_o & !sda_low);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  eec_master dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .done(done), .status(status), .scl(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));

  eec_eeprom_model #(.BUSY_NS(45000)) mem_model (.scl(scl), .sda(sda),
    .sda_low(sda_low));

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic do_cmd(input eec_pkg::eec_op_e op, input logic [7:0] a,
                        input logic [2:0] n, input logic [7:0] wd);
    int i;
    rd_q.delete();
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd       <= {op, a, n};
    wr_valid  <= (op == eec_pkg::EEC_OP_WRITE);
    wr_data   <= wd;
    for (i = 0; i < 100000; i++) begin
      @(posedge clk);
      if (cmd_valid && cmd_ready) cmd_valid <= 1'b0;
      if (wr_valid && wr_ready) wr_data <= wr_data + 8'h01;
      if (rd_valid === 1'b1) rd_q.push_back(rd_data);
      if (done === 1'b1) break;
    end
    wr_valid <= 1'b0;
    if (i == 100000) begin
      n_errors++;
      $display("wrong value done: expected 1, seen 0");
      print_verdict();
    end
  endtask : do_cmd

  task automatic t_page_err();
    do_cmd(eec_pkg::EEC_OP_WRITE, 8'h06, 3'h2, 8'h11);
    chk("status", 8'h01, {6'h00, status});
    chk("scl", 8'h01, {7'h00, scl});
    chk("sda_o", 8'h00, {7'h00, sda_o});
    chk("mem 06", 8'h3a, mem_model.mem[8'h06]);
    $display("test page_err done");
  endtask : t_page_err

  task automatic t_write();
    do_cmd(eec_pkg::EEC_OP_WRITE, 8'hfd, 3'h1, 8'ha5);
    chk("status", 8'h00, {6'h00, status});
    chk("mem fd", 8'ha5, mem_model.mem[8'hfd]);
    chk("mem fe", 8'ha6, mem_model.mem[8'hfe]);
    chk("mem ff", 8'hc3, mem_model.mem[8'hff]);
    $display("test write done");
  endtask : t_write

  task automatic t_poll();
    do_cmd(eec_pkg::EEC_OP_POLL, 8'h00, 3'h0, 8'h00);
    chk("status", 8'h02, {6'h00, status});
    $display("test poll done");
  endtask : t_poll

  task automatic t_read();
    do_cmd(eec_pkg::EEC_OP_READ_CUR, 8'h00, 3'h1, 8'h00);
    chk("rd count", 8'h02, 8'(rd_q.size()));
    chk("rd 0", 8'hc3, rd_q[0]);
    chk("rd 1", 8'h3c, rd_q[1]);
    chk("status", 8'h00, {6'h00, status});
    chk("bus idle", 8'h03, {6'h00, scl, sda});
    $display("test read done");
  endtask : t_read

  task automatic t_rand();
    do_cmd(eec_pkg::EEC_OP_READ_RAND, 8'h40, 3'h0, 8'h00);
    chk("rd count", 8'h01, 8'(rd_q.size()));
    chk("rd 40", 8'h7c, rd_q[0]);
    chk("status", 8'h00, {6'h00, status});
    $display("test rand_read done");
  endtask : t_rand

  initial begin
    rst_n     = 1'b0;
    cmd_valid = 1'b0;
    cmd       = '0;
    wr_valid  = 1'b0;
    wr_data   = 8'h00;
    n_errors  = 0;
    checked   = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_page_err();
    t_write();
    t_poll();
    t_read();
    t_rand();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
